// ===== logic/sfm_top.sv
// Serial queue manager: shared byte RAM, register port and transmit staging FIFO
`timescale 1ns/1ns

module sfm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic flush_i,
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } sfm_fifo_st_t;

  sfm_fifo_st_t s_r;
  sfm_fifo_st_t s_nxt;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  assign in_ready_o = (s_r.cnt != FULL_CNT);
  assign out_valid_o = (s_r.cnt != '0);
  assign out_data_o = mem[s_r.rp];
  assign push = ce_i & in_valid_i & in_ready_o;
  assign pop = ce_i & out_valid_o & out_ready_i;

  // Pointers wrap naturally, so DEPTH must be a power of two
  always_comb begin
    s_nxt = s_r;
    if (push) begin
      s_nxt.wp = s_r.wp + AW'(1);
    end
    if (pop) begin
      s_nxt.rp = s_r.rp + AW'(1);
    end
    if (push && !pop) begin
      s_nxt.cnt = s_r.cnt + (AW+1)'(1);
    end else if (pop && !push) begin
      s_nxt.cnt = s_r.cnt - (AW+1)'(1);
    end
    if (ce_i && flush_i) begin
      s_nxt = '0;
    end
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      s_r <= '0;
    end else if (ce_i) begin
      s_r <= s_nxt;
    end
  end

  always_ff @(posedge clock_i) begin
    if (push) begin
      mem[s_r.wp] <= in_data_i;
    end
  end
endmodule

// What this block does
// - Transmit clear bit empties the transmit queue
// - Receive clear bit empties the receive queue
// - Six enable bits gate the six flags
// - Enabled flags also need CPU peripheral enable
// - Data port write appends byte to transmit
// - Data port read pops oldest receive byte
// - Size field sets receive capacity, max 182
// - Remaining RAM becomes transmit capacity
// - Bytes beyond receive capacity are discarded
// - Full duplex byte link up to 1.288 Mbit/s
// - Link timing from shared prescaler, outside here
// - Serial port buffers byte during handoff
// - Writes go transmit, reads from receive
// - Write when transmit full sets collision flag
// - Byte into full receive sets overrun
module sfm_top (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire sfm_pkg::sfm_sfr_req_t sfr_req_i,
  output logic [7:0] sfr_rdata_o,
  input wire logic cpu_peripheral_irq_enable_i,
  output logic irq_o,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  output logic rx_ack_o,
  output logic tx_valid_o,
  output logic [7:0] tx_data_o,
  input wire logic tx_ready_i
);
  sfm_pkg::sfm_state_t s_r;
  sfm_pkg::sfm_state_t s_nxt;
  logic [7:0] ram [256];

  logic [8:0] rx_cap;
  logic [8:0] tx_cap;
  logic rx_full;
  logic rx_empty;
  logic tx_full;
  logic tx_empty;
  logic rx_high_lvl;
  logic tx_low_lvl;
  logic wr_en_reg;
  logic wr_data;
  logic wr_flags;
  logic rd_data;
  logic tx_clear;
  logic rx_clear;
  logic tx_push;
  logic rx_push;
  logic rx_pop;
  logic tx_move;
  logic stage_ready;
  logic [7:0] rx_head;
  logic [7:0] tx_head;
  logic [7:0] tx_wr_addr;
  logic [5:0] events;
  logic [7:0] status;
  logic [8:0] tx_free;

  function automatic logic hit(input sfm_pkg::sfm_sfr_req_t req, input logic [7:0] addr);
    return req.addr == addr;
  endfunction

  // Sizes above the maximum are clamped rather than letting receive eat the transmit side
  function automatic logic [8:0] rx_cap_of(input logic [7:0] size);
    return ({1'b0, size} > sfm_pkg::RX_CAP_MAX) ? sfm_pkg::RX_CAP_MAX : {1'b0, size};
  endfunction

  function automatic logic [8:0] wrap_inc(input logic [8:0] ptr, input logic [8:0] cap);
    return ((ptr + 9'h001) >= cap) ? 9'h000 : ptr + 9'h001;
  endfunction

  function automatic logic [7:0] tx_addr(input logic [8:0] base, input logic [8:0] ptr);
    return 8'(base + ptr);
  endfunction

  assign rx_cap = rx_cap_of(s_r.rx_size);
  assign tx_cap = sfm_pkg::RAM_BYTES - rx_cap;
  assign rx_full = (s_r.rx_cnt >= rx_cap);
  assign rx_empty = (s_r.rx_cnt == 9'h000);
  assign tx_full = (s_r.tx_cnt >= tx_cap);
  assign tx_empty = (s_r.tx_cnt == 9'h000);
  assign rx_high_lvl = (s_r.rx_cnt >= {1'b0, s_r.rx_high});
  assign tx_low_lvl = (s_r.tx_cnt <= {1'b0, s_r.tx_low});
  assign tx_free = tx_full ? 9'h000 : tx_cap - s_r.tx_cnt;

  assign wr_en_reg = ce_i & sfr_req_i.wr & hit(sfr_req_i, sfm_pkg::ADDR_IRQ_EN);
  assign wr_data = ce_i & sfr_req_i.wr & hit(sfr_req_i, sfm_pkg::ADDR_DATA);
  assign wr_flags = ce_i & sfr_req_i.wr & hit(sfr_req_i, sfm_pkg::ADDR_FLAGS);
  assign rd_data = ce_i & sfr_req_i.rd & hit(sfr_req_i, sfm_pkg::ADDR_DATA);
  assign tx_clear = wr_en_reg & sfr_req_i.wdata[sfm_pkg::BIT_TX_CLEAR];
  assign rx_clear = wr_en_reg & sfr_req_i.wdata[sfm_pkg::BIT_RX_CLEAR];

  // Write path feeds only the transmit queue, read path only the receive queue
  assign tx_push = wr_data & ~tx_full;
  assign rx_pop = rd_data & ~rx_empty;
  // Receive strobes arrive paced by the external shared prescaler
  assign rx_push = ce_i & rx_valid_i & ~rx_full;
  // Transmit drain runs in the same cycle as receive fill, full duplex
  assign tx_move = ce_i & ~tx_empty & stage_ready;
  // Serial side keeps its own holding byte and may retry while ack is low
  assign rx_ack_o = ~rx_full;

  assign rx_head = ram[s_r.rx_rp];
  assign tx_head = ram[tx_addr(rx_cap, s_r.tx_rp)];
  assign tx_wr_addr = tx_addr(rx_cap, s_r.tx_wp);

  always_comb begin
    events = sfm_pkg::FLAGS_RESET;
    events[sfm_pkg::BIT_WCOL] = wr_data & tx_full;
    events[sfm_pkg::BIT_TX_LOW] = ce_i & tx_low_lvl;
    events[sfm_pkg::BIT_TX_FULL] = ce_i & tx_full;
    events[sfm_pkg::BIT_RX_HIGH] = ce_i & rx_high_lvl;
    events[sfm_pkg::BIT_RX_OVR] = ce_i & rx_valid_i & rx_full;
    events[sfm_pkg::BIT_RX_FULL] = ce_i & rx_full;
  end

  always_comb begin
    status = sfm_pkg::REG_RESET;
    status[sfm_pkg::ST_TX_LOW] = tx_low_lvl;
    status[sfm_pkg::ST_TX_FULL] = tx_full;
    status[sfm_pkg::ST_TX_EMPTY] = tx_empty;
    status[sfm_pkg::ST_RX_HIGH] = rx_high_lvl;
    status[sfm_pkg::ST_RX_FULL] = rx_full;
    status[sfm_pkg::ST_RX_EMPTY] = rx_empty;
  end

  always_comb begin
    s_nxt = s_r;
    if (wr_en_reg) begin
      s_nxt.irq_en = sfr_req_i.wdata;
    end
    if (ce_i && sfr_req_i.wr) begin
      unique case (sfr_req_i.addr)
        sfm_pkg::ADDR_RX_SIZE: s_nxt.rx_size = sfr_req_i.wdata;
        sfm_pkg::ADDR_RX_HIGH: s_nxt.rx_high = sfr_req_i.wdata;
        sfm_pkg::ADDR_TX_LOW: s_nxt.tx_low = sfr_req_i.wdata;
        default: s_nxt.rx_size = s_r.rx_size;
      endcase
    end
    // Register reads answer one cycle later from a flop
    if (ce_i && sfr_req_i.rd) begin
      unique case (sfr_req_i.addr)
        sfm_pkg::ADDR_IRQ_EN: s_nxt.rdata = s_r.irq_en;
        sfm_pkg::ADDR_DATA: s_nxt.rdata = rx_empty ? sfm_pkg::REG_RESET : rx_head;
        sfm_pkg::ADDR_RX_SIZE: s_nxt.rdata = s_r.rx_size;
        sfm_pkg::ADDR_RX_HIGH: s_nxt.rdata = s_r.rx_high;
        sfm_pkg::ADDR_TX_LOW: s_nxt.rdata = s_r.tx_low;
        sfm_pkg::ADDR_TX_FREE: s_nxt.rdata = 8'(tx_free);
        sfm_pkg::ADDR_RX_FILL: s_nxt.rdata = 8'(s_r.rx_cnt);
        sfm_pkg::ADDR_STATUS: s_nxt.rdata = status;
        sfm_pkg::ADDR_FLAGS: s_nxt.rdata = {2'b00, s_r.flags};
        default: s_nxt.rdata = sfm_pkg::REG_RESET;
      endcase
    end

    if (rx_push) begin
      s_nxt.rx_wp = 8'(wrap_inc({1'b0, s_r.rx_wp}, rx_cap));
    end
    if (rx_pop) begin
      s_nxt.rx_rp = 8'(wrap_inc({1'b0, s_r.rx_rp}, rx_cap));
    end
    if (rx_push && !rx_pop) begin
      s_nxt.rx_cnt = s_r.rx_cnt + 9'h001;
    end else if (rx_pop && !rx_push) begin
      s_nxt.rx_cnt = s_r.rx_cnt - 9'h001;
    end

    if (tx_push) begin
      s_nxt.tx_wp = wrap_inc(s_r.tx_wp, tx_cap);
    end
    if (tx_move) begin
      s_nxt.tx_rp = wrap_inc(s_r.tx_rp, tx_cap);
    end
    if (tx_push && !tx_move) begin
      s_nxt.tx_cnt = s_r.tx_cnt + 9'h001;
    end else if (tx_move && !tx_push) begin
      s_nxt.tx_cnt = s_r.tx_cnt - 9'h001;
    end

    // A clear beats any push or pop in the same cycle; levels follow from the counts
    if (rx_clear) begin
      s_nxt.rx_wp = 8'h00;
      s_nxt.rx_rp = 8'h00;
      s_nxt.rx_cnt = 9'h000;
    end
    if (tx_clear) begin
      s_nxt.tx_wp = 9'h000;
      s_nxt.tx_rp = 9'h000;
      s_nxt.tx_cnt = 9'h000;
    end

    if (wr_flags) begin
      if (sfr_req_i.wdata[sfm_pkg::BIT_FLAG_CLEAR]) begin
        s_nxt.flags = s_r.flags & ~sfr_req_i.wdata[5:0];
      end else begin
        s_nxt.flags = s_r.flags | sfr_req_i.wdata[5:0];
      end
    end
    // Hardware set wins over a software clear in the same cycle
    s_nxt.flags = s_nxt.flags | events;
    // Local enables ANDed with the CPU-wide enable
    s_nxt.irq = cpu_peripheral_irq_enable_i & (|(s_nxt.flags & s_nxt.irq_en[5:0]));
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      s_r <= '0;
    end else if (ce_i) begin
      s_r <= s_nxt;
    end
  end

  // Receive and transmit regions do not overlap while the size field is unchanged, so both writes may land together
  always_ff @(posedge clock_i) begin
    if (rx_push) begin
      ram[s_r.rx_wp] <= rx_data_i;
    end
    if (tx_push) begin
      ram[tx_wr_addr] <= sfr_req_i.wdata;
    end
  end

  // Staging buffer decouples the RAM from a slow or stalled transmitter
  sfm_fifo #(
    .WIDTH(sfm_pkg::BYTE_W),
    .DEPTH(sfm_pkg::TX_STAGE_DEPTH)
  ) u_tx_stage (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .flush_i(tx_clear),
    .in_valid_i(~tx_empty),
    .in_data_i(tx_head),
    .in_ready_o(stage_ready),
    .out_valid_o(tx_valid_o),
    .out_data_o(tx_data_o),
    .out_ready_i(tx_ready_i)
  );

  assign sfr_rdata_o = s_r.rdata;
  assign irq_o = s_r.irq;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);

  sequence seq_full_write;
    wr_data && tx_full;
  endsequence

  sequence seq_overrun;
    ce_i && rx_valid_i && rx_full;
  endsequence

  AST_TX_CLEAR: assert property (tx_clear |=> (s_r.tx_cnt == 9'h000) && tx_empty)
    else $error("transmit clear did not empty queue");
  AST_RX_CLEAR: assert property (rx_clear |=> (s_r.rx_cnt == 9'h000) && (s_r.rx_rp == 8'h00))
    else $error("receive clear did not empty queue");
  AST_TX_APPEND: assert property (tx_push && !tx_move && !tx_clear |=>
    s_r.tx_cnt == $past(s_r.tx_cnt) + 9'h001)
    else $error("transmit write did not grow queue");
  AST_RX_POP: assert property (rx_pop && !rx_clear |=>
    (sfr_rdata_o == $past(rx_head)) && (s_r.rx_cnt == $past(s_r.rx_cnt) - 9'h001 + 9'($past(rx_push))))
    else $error("receive read returned wrong byte or count");
  AST_RX_CAP: assert property ((s_r.rx_cnt <= sfm_pkg::RX_CAP_MAX) &&
    (s_r.rx_cnt <= {1'b0, s_r.rx_size}))
    else $error("receive count beyond maximum capacity");
  AST_SHARE: assert property (tx_full |->
    (10'(s_r.tx_cnt) + 10'(rx_cap)) >= 10'(sfm_pkg::RAM_BYTES))
    else $error("transmit full before RAM is used up");
  AST_WCOL: assert property (seq_full_write |=> s_r.flags[sfm_pkg::BIT_WCOL] &&
    (s_r.tx_cnt <= $past(s_r.tx_cnt)))
    else $error("write collision not flagged or byte stored");
  AST_OVERRUN: assert property (seq_overrun and !rx_pop and !rx_clear |=>
    s_r.flags[sfm_pkg::BIT_RX_OVR] && $stable(s_r.rx_cnt))
    else $error("overrun byte not dropped or not flagged");
  AST_IRQ_GLOBAL: assert property (ce_i && !cpu_peripheral_irq_enable_i |=> !irq_o)
    else $error("interrupt raised without CPU enable");
  AST_IRQ_OR: assert property (ce_i && cpu_peripheral_irq_enable_i && !wr_flags && !wr_en_reg
    && (|(s_r.flags & s_r.irq_en[5:0])) |=> irq_o)
    else $error("enabled flag did not raise interrupt");
  AST_STICKY: assert property (ce_i && !wr_flags |=>
    (s_r.flags & $past(s_r.flags)) == $past(s_r.flags))
    else $error("flag dropped without software clear");
endmodule

// ===== pkg/sfm_pkg.sv
// Constants and carrier types of the serial queue manager
package sfm_pkg;
  localparam logic [7:0] ADDR_RX_HIGH = 8'h9A;
  localparam logic [7:0] ADDR_TX_LOW = 8'h9B;
  localparam logic [7:0] ADDR_TX_FREE = 8'h9C;
  localparam logic [7:0] ADDR_RX_FILL = 8'h9D;
  localparam logic [7:0] ADDR_STATUS = 8'h9E;
  localparam logic [7:0] ADDR_FLAGS = 8'h9F;
  localparam logic [7:0] ADDR_IRQ_EN = 8'hA1;
  localparam logic [7:0] ADDR_DATA = 8'hA2;
  localparam logic [7:0] ADDR_RX_SIZE = 8'hA3;

  // Enable / flush register fields; flag bits use the same positions 5..0
  localparam int BIT_TX_CLEAR = 7;
  localparam int BIT_RX_CLEAR = 6;
  localparam int BIT_WCOL = 5;
  localparam int BIT_TX_LOW = 4;
  localparam int BIT_TX_FULL = 3;
  localparam int BIT_RX_HIGH = 2;
  localparam int BIT_RX_OVR = 1;
  localparam int BIT_RX_FULL = 0;
  // Flag register bit 7: one clears the written ones, zero sets them
  localparam int BIT_FLAG_CLEAR = 7;

  // Status register fields
  localparam int ST_TX_LOW = 5;
  localparam int ST_TX_FULL = 4;
  localparam int ST_TX_EMPTY = 3;
  localparam int ST_RX_HIGH = 2;
  localparam int ST_RX_FULL = 1;
  localparam int ST_RX_EMPTY = 0;

  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [5:0] FLAGS_RESET = 6'h00;

  localparam logic [8:0] RAM_BYTES = 9'h100;
  localparam logic [8:0] RX_CAP_MAX = 9'h0B6;
  localparam int TX_STAGE_DEPTH = 32;
  localparam int BYTE_W = 8;

  // Link figures; the serial engine itself lives outside this block
  localparam int CLK_HZ = 25_000_000;
  localparam int HOST_BIT_RATE_BPS = 1_288_000;
  localparam int SERIAL_REF_HZ = 27_120_000;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfm_sfr_req_t;

  typedef struct packed {
    logic [7:0] irq_en;
    logic [7:0] rx_size;
    logic [7:0] rx_high;
    logic [7:0] tx_low;
    logic [7:0] rdata;
    logic [5:0] flags;
    logic [7:0] rx_wp;
    logic [7:0] rx_rp;
    logic [8:0] rx_cnt;
    logic [8:0] tx_wp;
    logic [8:0] tx_rp;
    logic [8:0] tx_cnt;
    logic irq;
  } sfm_state_t;
endpackage

// ===== verification/sfm_serial_model.sv
// Behavioural serial engine on the far side of the queue manager
`timescale 1ns/1ns

module sfm_serial_model (
  input wire logic clock_i,
  input wire logic stall_i,
  output logic rx_valid_o,
  output logic [7:0] rx_data_o,
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_data_i,
  output logic tx_ready_o
);
  logic [7:0] tx_q[$];

  initial begin
    rx_valid_o = 1'b0;
    rx_data_o = 8'h00;
  end

  // Stalling holds the transmitter busy so the queue can fill up
  assign tx_ready_o = ~stall_i;

  // One strobe per whole byte from the receive holding buffer
  task automatic send_byte(input logic [7:0] b);
    @(posedge clock_i);
    #1;
    rx_valid_o = 1'b1;
    rx_data_o = b;
    @(posedge clock_i);
    #1;
    rx_valid_o = 1'b0;
    rx_data_o = ~b;  // Stale byte must not look valid to the sampler
  endtask

  always @(posedge clock_i) begin
    if (tx_valid_i && tx_ready_o) begin
      tx_q.push_back(tx_data_i);
    end
  end
endmodule

// ===== verification/tb_top.sv
// Self-checking testbench of the serial queue manager
`timescale 1ns/1ns

module tb_top;
  logic clock_i, reset_i, cpu_en, stall, irq, tx_valid, tx_ready, rx_valid, ce, rx_ack;
  logic [7:0] rdata, tx_data, rx_data, d;
  sfm_pkg::sfm_sfr_req_t req;
  int n_mismatch = 0;
  int check_count = 0;

  sfm_top i_dut (
    .clock_i(clock_i), .reset_i(reset_i), .ce_i(ce), .sfr_req_i(req),
    .sfr_rdata_o(rdata), .cpu_peripheral_irq_enable_i(cpu_en), .irq_o(irq),
    .rx_valid_i(rx_valid), .rx_data_i(rx_data), .rx_ack_o(rx_ack),
    .tx_valid_o(tx_valid), .tx_data_o(tx_data), .tx_ready_i(tx_ready)
  );

  sfm_serial_model i_link (
    .clock_i(clock_i), .stall_i(stall), .rx_valid_o(rx_valid), .rx_data_o(rx_data),
    .tx_valid_i(tx_valid), .tx_data_i(tx_data), .tx_ready_o(tx_ready)
  );

  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s: saw %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock_i);
    #1;
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = v;
    @(posedge clock_i);
    #1;
    req.wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clock_i);
    #1;
    req.rd = 1'b1;
    req.addr = a;
    @(posedge clock_i);
    #1;
    req.rd = 1'b0;
    v = rdata;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input string what);
    logic [7:0] v;
    rd(a, v);
    check(v, exp, what);
  endtask

  task automatic t_reset();
    // Size zero after reset means no receive room at all
    check({7'h00, rx_ack}, 8'h00, "ack low at zero size");
    rchk(8'hA1, 8'h00, "enable reset");
    rchk(8'hA2, 8'h00, "data reset");
    rchk(8'hA3, 8'h00, "size reset");
    rchk(8'h55, 8'h00, "unmapped read");
    wr(8'hA3, 8'h5A);
    rchk(8'hA3, 8'h5A, "size readback");
    ce = 1'b0;
    wr(8'hA3, 8'hA5);
    ce = 1'b1;
    rchk(8'hA3, 8'h5A, "size frozen while disabled");
    wr(8'h9B, 8'h11);
    rchk(8'h9B, 8'h11, "tx low level readback");
    wr(8'hA1, 8'h3F);
    rchk(8'hA1, 8'h3F, "enable readback");
    wr(8'hA1, 8'h00);
  endtask

  task automatic t_rx();
    wr(8'h9A, 8'h03);
    wr(8'hA3, 8'h04);
    for (int i = 0; i < 6; i++) i_link.send_byte(8'hA0 + 8'(i));
    rchk(8'h9D, 8'h04, "rx fill at capacity");
    rd(8'h9F, d);
    check({7'h00, d[1]}, 8'h01, "overrun flag");
    rd(8'h9E, d);
    check({6'h00, d[2:1]}, 8'h03, "rx high and full status");
    check({7'h00, rx_ack}, 8'h00, "ack low when full");
    for (int i = 0; i < 4; i++) rchk(8'hA2, 8'hA0 + 8'(i), "rx order");
    rchk(8'hA2, 8'h00, "pop when empty");
    rchk(8'h9D, 8'h00, "rx fill drained");
    check({7'h00, rx_ack}, 8'h01, "ack high when drained");
  endtask

  task automatic t_clamp();
    wr(8'hA3, 8'hC8);
    for (int i = 0; i < 183; i++) i_link.send_byte(8'(i));
    rchk(8'h9D, 8'hB6, "clamped capacity");
    wr(8'hA1, 8'h40); // Receive clear on its own
    rchk(8'h9D, 8'h00, "rx fill after clear");
    rd(8'h9E, d);
    check({6'h00, d[1:0]}, 8'h01, "rx status after clear");
    wr(8'hA1, 8'h00);
  endtask

  task automatic t_tx();
    int k;
    wr(8'hA1, 8'h80); // Transmit clear on its own
    wr(8'hA1, 8'h00);
    rchk(8'h9C, 8'h4A, "tx share of ram");
    stall = 1'b1;
    // 74 RAM bytes plus 32 staged fill the path; the rest collide
    for (int i = 0; i < 110; i++) wr(8'hA2, 8'(i));
    rd(8'h9F, d);
    check({7'h00, d[5]}, 8'h01, "collision flag");
    rchk(8'h9C, 8'h00, "tx free when full");
    rd(8'h9E, d);
    check({7'h00, d[4]}, 8'h01, "tx full status");
    stall = 1'b0;
    for (k = 0; k < 1000 && i_link.tx_q.size() < 106; k++) @(posedge clock_i);
    repeat (5) @(posedge clock_i);
    #1;
    check(8'(i_link.tx_q.size()), 8'h6A, "tx byte count");
    for (int i = 0; i < 106; i++) check(i_link.tx_q[i], 8'(i), "tx order");
    stall = 1'b1;
    for (int i = 0; i < 3; i++) wr(8'hA2, 8'hC0);
    wr(8'hA1, 8'h80);
    check({7'h00, tx_valid}, 8'h00, "tx idle after clear");
    rchk(8'h9C, 8'h4A, "tx free after clear");
    rd(8'h9E, d);
    check({7'h00, d[3]}, 8'h01, "tx empty status");
    wr(8'hA1, 8'h00);
    stall = 1'b0;
  endtask

  task automatic t_irq();
    cpu_en = 1'b1;
    repeat (2) @(posedge clock_i);
    #1;
    check({7'h00, irq}, 8'h00, "all sources masked");
    for (int i = 0; i < 6; i++) begin
      wr(8'h9F, 8'hBF);
      wr(8'hA1, 8'h01 << i);
      wr(8'h9F, 8'h01 << i);
      rd(8'h9F, d);
      check({7'h00, d[i]}, 8'h01, "flag held");
      repeat (2) @(posedge clock_i);
      #1;
      check({7'h00, irq}, 8'h01, "enabled source");
      cpu_en = 1'b0;
      repeat (2) @(posedge clock_i);
      #1;
      check({7'h00, irq}, 8'h00, "cpu enable low");
      cpu_en = 1'b1;
    end
  endtask

  initial begin
    req = '0;
    ce = 1'b1;
    cpu_en = 1'b0;
    stall = 1'b0;
    reset_i = 1'b1;
    repeat (3) @(posedge clock_i);
    #1;
    reset_i = 1'b0;
    t_reset();
    t_rx();
    t_clamp();
    t_tx();
    t_irq();
    final_report();
  end

  // Whole run needs under a thousand cycles; this leaves ample margin
  initial begin
    repeat (20000) @(posedge clock_i);
    n_mismatch++;
    final_report();
  end
endmodule
